// ===== arw_pkg.sv
/*
 * shared constants for the converter result / window register block:
 * register indexes, field positions, reset values, codes.
 * assumes a 16-bit register port clocked with the core clock.
 */
package arw_pkg;
    // ********************************
    // register map (indexes, word address)
    // ********************************
    localparam logic [3:0] ADDR_RESULT = 4'h0;
    localparam logic [3:0] ADDR_MEM_CTL = 4'h1;
    localparam logic [3:0] ADDR_HIGH_THR = 4'h2;
    localparam logic [3:0] ADDR_LOW_THR = 4'h3;
    localparam logic [3:0] ADDR_INT_EN = 4'h4;
    localparam logic [3:0] ADDR_INT_FLAGS = 4'h5;
    localparam logic [3:0] ADDR_INT_VEC = 4'h6;
    localparam logic [3:0] ADDR_CONV_CTL = 4'h7;
    // ********************************
    // fields
    // ********************************
    localparam int REF_LSB = 4;
    localparam int REF_MSB = 6;
    localparam int CHAN_LSB = 0;
    localparam int CHAN_MSB = 3;
    localparam int CTL_ENABLE = 0;
    localparam int CTL_FORMAT = 1;
    localparam int CTL_RES_LSB = 2;
    localparam int CTL_SEQ_LSB = 4;
    localparam int NUM_IRQ = 6;
    localparam int IRQ_COMPLETE = 0;
    localparam int IRQ_INSIDE = 1;
    localparam int IRQ_BELOW = 2;
    localparam int IRQ_ABOVE = 3;
    localparam int IRQ_RES_OVF = 4;
    localparam int IRQ_TIME_OVF = 5;
    // ********************************
    // reset values and codes
    // ********************************
    localparam logic [15:0] RST_MEM_CTL = 16'h0000;
    localparam logic [15:0] RST_HIGH_UNS = 16'h03ff;
    localparam logic [15:0] RST_LOW_UNS = 16'h0000;
    localparam logic [15:0] RST_HIGH_SGN = 16'h01ff;
    localparam logic [15:0] RST_LOW_SGN = 16'h0200;
    localparam logic [1:0] RST_RES = 2'h1;
    localparam logic [1:0] RES_8 = 2'h0;
    localparam logic [1:0] RES_10 = 2'h1;
    localparam logic [1:0] RES_12 = 2'h2;
    localparam logic [1:0] SEQ_SEQUENCE = 2'h1;
    localparam logic [1:0] SEQ_REPEAT_SEQ = 2'h3;
    localparam logic [3:0] CHAN_MAX = 4'he;
    localparam logic [7:0] VEC_NONE = 8'h00;
    localparam logic [7:0] VEC_RES_OVF = 8'h02;
    localparam logic [7:0] VEC_TIME_OVF = 8'h04;
    localparam logic [7:0] VEC_ABOVE = 8'h06;
    localparam logic [7:0] VEC_BELOW = 8'h08;
    localparam logic [7:0] VEC_INSIDE = 8'h0a;
    localparam logic [7:0] VEC_COMPLETE = 8'h0c;
endpackage : arw_pkg

// ===== arw_regs.sv
/*
 * register side of an analog converter: result read-back formatting,
 * memory control, window comparator, interrupt enables, flags, vector.
 * assumes the converter core presents results and events as one-cycle
 * pulses on core_clk, and a master that follows the simple strobe port.
 */
// Operation
// - signed view: left justified, low bits zero
// - result stored unsigned, converted on read
// - bits 6-4 pick reference pair
// - gated fields written only while enable clear
// - clearing enable then writing takes effect immediately
// - bits 3-0 pick channel, up to 14
// - sequence modes read back active channel
// - unsigned thresholds right justified
// - signed thresholds left justified, low bits zero
// - six enable bits gate interrupt requests
// - reserved bits read as zero
// - completion flag set, cleared by result read
// - window flags from threshold comparisons
// - time and result overflow flags
// - vector reports highest pending; write clears all
`timescale 1ns/1ns
module arw_regs (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [15:0] reg_rdata,
    // converter core
    input wire logic conv_done,
    input wire logic [11:0] conv_result,
    input wire logic conv_trigger,
    input wire logic conv_busy,
    input wire logic [3:0] conv_channel,
    // configuration toward the core
    output logic [2:0] reference_select,
    output logic [3:0] channel_select,
    output logic conversion_enable,
    output logic format_select,
    output logic [1:0] resolution,
    output logic [1:0] sequence_mode,
    // interrupt
    output logic irq
);
    // ********************************
    // state
    // ********************************
    logic [11:0] result_reg;
    logic result_unread_reg;
    logic [15:0] high_thr_reg;
    logic [15:0] low_thr_reg;
    logic [5:0] enables_reg;
    logic [5:0] flags_reg;
    logic [15:0] rdata_next;
    logic [5:0] set_next;
    logic [5:0] clr_next;
    logic [15:0] cmp_val;
    logic wr_result;
    logic rd_result;
    logic cfg_open;

    // left-justify an unsigned result into two's complement, low bits masked
    function automatic logic [15:0] to_signed_view(input logic [11:0] v,
                                                   input logic [1:0] res);
        logic [15:0] s;
        s = {~v[11], v[10:0], 4'h0};
        case (res)
            arw_pkg::RES_8: s = {~v[7], v[6:0], 8'h00};
            arw_pkg::RES_10: s = {~v[9], v[8:0], 6'h00};
            default: s = {~v[11], v[10:0], 4'h0};
        endcase
        return s;
    endfunction : to_signed_view

    function automatic logic [15:0] unsigned_mask(input logic [1:0] res);
        logic [15:0] m;
        m = 16'h0fff;
        case (res)
            arw_pkg::RES_8: m = 16'h00ff;
            arw_pkg::RES_10: m = 16'h03ff;
            default: m = 16'h0fff;
        endcase
        return m;
    endfunction : unsigned_mask

    function automatic logic [15:0] signed_mask(input logic [1:0] res);
        logic [15:0] m;
        m = 16'hfff0;
        case (res)
            arw_pkg::RES_8: m = 16'hff00;
            arw_pkg::RES_10: m = 16'hffc0;
            default: m = 16'hfff0;
        endcase
        return m;
    endfunction : signed_mask

    // signed compare of two's complement views, unsigned otherwise
    function automatic logic greater(input logic [15:0] a, input logic [15:0] b,
                                     input logic sgn);
        logic r;
        r = sgn ? ($signed(a) > $signed(b)) : (a > b);
        return r;
    endfunction : greater

    function automatic logic [7:0] vector_of(input logic [5:0] f);
        logic [7:0] v;
        v = arw_pkg::VEC_NONE;
        if (f[arw_pkg::IRQ_RES_OVF]) v = arw_pkg::VEC_RES_OVF;
        else if (f[arw_pkg::IRQ_TIME_OVF]) v = arw_pkg::VEC_TIME_OVF;
        else if (f[arw_pkg::IRQ_ABOVE]) v = arw_pkg::VEC_ABOVE;
        else if (f[arw_pkg::IRQ_BELOW]) v = arw_pkg::VEC_BELOW;
        else if (f[arw_pkg::IRQ_INSIDE]) v = arw_pkg::VEC_INSIDE;
        else if (f[arw_pkg::IRQ_COMPLETE]) v = arw_pkg::VEC_COMPLETE;
        return v;
    endfunction : vector_of

    assign wr_result = reg_wr && reg_addr == arw_pkg::ADDR_RESULT;
    assign rd_result = reg_rd && reg_addr == arw_pkg::ADDR_RESULT;
    assign cfg_open = !conversion_enable;

    // ********************************
    // conversion control register
    // ********************************
    // enable can always be cleared; other fields only while it is clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            conversion_enable <= 1'b0;
            format_select <= 1'b0;
            resolution <= arw_pkg::RST_RES;
            sequence_mode <= 2'h0;
        end else if (reg_wr && reg_addr == arw_pkg::ADDR_CONV_CTL) begin
            conversion_enable <= reg_wdata[arw_pkg::CTL_ENABLE];
            if (cfg_open) begin
                format_select <= reg_wdata[arw_pkg::CTL_FORMAT];
                resolution <= reg_wdata[arw_pkg::CTL_RES_LSB +: 2];
                sequence_mode <= reg_wdata[arw_pkg::CTL_SEQ_LSB +: 2];
            end
        end
    end

    // ********************************
    // memory control
    // ********************************
    // outputs go straight to the core; writes are taken only while enable is clear
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            reference_select <= arw_pkg::RST_MEM_CTL[arw_pkg::REF_MSB:arw_pkg::REF_LSB];
            channel_select <= arw_pkg::RST_MEM_CTL[arw_pkg::CHAN_MSB:arw_pkg::CHAN_LSB];
        end else if (reg_wr && reg_addr == arw_pkg::ADDR_MEM_CTL && cfg_open) begin
            reference_select <= reg_wdata[arw_pkg::REF_MSB:arw_pkg::REF_LSB];
            // codes above 14 have no input; they are clamped
            channel_select <= (reg_wdata[3:0] > arw_pkg::CHAN_MAX) ?
                              arw_pkg::CHAN_MAX : reg_wdata[3:0];
        end
    end

    // ********************************
    // thresholds
    // ********************************
    // one store; its reset value follows the format selected at reset
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            high_thr_reg <= arw_pkg::RST_HIGH_UNS;
            low_thr_reg <= arw_pkg::RST_LOW_UNS;
        end else if (reg_wr && reg_addr == arw_pkg::ADDR_HIGH_THR) begin
            high_thr_reg <= reg_wdata;
        end else if (reg_wr && reg_addr == arw_pkg::ADDR_LOW_THR) begin
            low_thr_reg <= reg_wdata;
        end else if (reg_wr && reg_addr == arw_pkg::ADDR_CONV_CTL && cfg_open
                     && reg_wdata[arw_pkg::CTL_FORMAT] != format_select) begin
            // defaults swap with the format while untouched
            if (high_thr_reg == (format_select ? arw_pkg::RST_HIGH_SGN : arw_pkg::RST_HIGH_UNS)
                && low_thr_reg == (format_select ? arw_pkg::RST_LOW_SGN : arw_pkg::RST_LOW_UNS))
            begin
                high_thr_reg <= format_select ? arw_pkg::RST_HIGH_UNS : arw_pkg::RST_HIGH_SGN;
                low_thr_reg <= format_select ? arw_pkg::RST_LOW_UNS : arw_pkg::RST_LOW_SGN;
            end
        end
    end

    // ********************************
    // result store
    // ********************************
    // a software write lands here too and spoils the stored value
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) begin
            result_reg <= 12'h000;
            result_unread_reg <= 1'b0;
        end else begin
            if (conv_done) begin
                result_reg <= conv_result & 12'(unsigned_mask(resolution));
            end else if (wr_result) begin
                result_reg <= reg_wdata[11:0];
            end
            if (conv_done || wr_result) result_unread_reg <= 1'b1;
            else if (rd_result) result_unread_reg <= 1'b0;
        end
    end

    // ********************************
    // window comparator and flags
    // ********************************
    always_comb begin
        // same format and justification as software sees the result
        cmp_val = format_select ? to_signed_view(conv_result, resolution)
                                : ({4'h0, conv_result} & unsigned_mask(resolution));
        set_next = 6'h00;
        set_next[arw_pkg::IRQ_COMPLETE] = conv_done;
        set_next[arw_pkg::IRQ_ABOVE] = conv_done &&
            greater(cmp_val, high_thr_reg & (format_select ? signed_mask(resolution)
                : unsigned_mask(resolution)), format_select);
        set_next[arw_pkg::IRQ_BELOW] = conv_done &&
            greater(low_thr_reg & (format_select ? signed_mask(resolution)
                : unsigned_mask(resolution)), cmp_val, format_select);
        set_next[arw_pkg::IRQ_INSIDE] = conv_done && !set_next[arw_pkg::IRQ_ABOVE]
            && !set_next[arw_pkg::IRQ_BELOW];
        set_next[arw_pkg::IRQ_TIME_OVF] = conv_trigger && conv_busy;
        set_next[arw_pkg::IRQ_RES_OVF] = (conv_done || wr_result) && result_unread_reg;
        clr_next = 6'h00;
        if (reg_wr && reg_addr == arw_pkg::ADDR_INT_VEC) clr_next = 6'h3f;
        else if (reg_wr && reg_addr == arw_pkg::ADDR_INT_FLAGS) clr_next = ~reg_wdata[5:0];
        else if (reg_rd && reg_addr == arw_pkg::ADDR_INT_FLAGS) clr_next = 6'h3f;
        if (rd_result) clr_next[arw_pkg::IRQ_COMPLETE] = 1'b1;
    end

    // a new event in the clearing cycle wins
    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) flags_reg <= 6'h00;
        else flags_reg <= (flags_reg & ~clr_next) | set_next;
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) enables_reg <= 6'h00;
        else if (reg_wr && reg_addr == arw_pkg::ADDR_INT_EN) enables_reg <= reg_wdata[5:0];
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) irq <= 1'b0;
        else irq <= |(((flags_reg & ~clr_next) | set_next) & enables_reg);
    end

    // ********************************
    // read path
    // ********************************
    always_comb begin
        rdata_next = 16'h0000;
        case (reg_addr)
            arw_pkg::ADDR_RESULT:
                rdata_next = format_select ? to_signed_view(result_reg, resolution)
                                           : {4'h0, result_reg};
            arw_pkg::ADDR_MEM_CTL: begin
                rdata_next[arw_pkg::REF_MSB:arw_pkg::REF_LSB] = reference_select;
                rdata_next[arw_pkg::CHAN_MSB:arw_pkg::CHAN_LSB] =
                    (sequence_mode == arw_pkg::SEQ_SEQUENCE
                     || sequence_mode == arw_pkg::SEQ_REPEAT_SEQ) ?
                    conv_channel : channel_select;
            end
            arw_pkg::ADDR_HIGH_THR: rdata_next = high_thr_reg;
            arw_pkg::ADDR_LOW_THR: rdata_next = low_thr_reg;
            arw_pkg::ADDR_INT_EN: rdata_next[5:0] = enables_reg;
            arw_pkg::ADDR_INT_FLAGS: rdata_next[5:0] = flags_reg;
            arw_pkg::ADDR_INT_VEC: rdata_next[7:0] = vector_of(flags_reg);
            arw_pkg::ADDR_CONV_CTL: begin
                rdata_next[arw_pkg::CTL_ENABLE] = conversion_enable;
                rdata_next[arw_pkg::CTL_FORMAT] = format_select;
                rdata_next[arw_pkg::CTL_RES_LSB +: 2] = resolution;
                rdata_next[arw_pkg::CTL_SEQ_LSB +: 2] = sequence_mode;
            end
            default: rdata_next = 16'h0000;
        endcase
    end

    always_ff @(posedge core_clk or posedge rst) begin
        if (rst) reg_rdata <= 16'h0000;
        else if (reg_rd) reg_rdata <= rdata_next;
        else reg_rdata <= 16'h0000;
    end
endmodule : arw_regs

// ===== arw_regs_sva.sv
/*
 * concurrent checks on the converter register block ports.
 * assumes the single core clock and the active-high async reset.
 */
`timescale 1ns/1ns
module arw_regs_sva (
    // clock and reset
    input wire logic core_clk,
    input wire logic rst,
    // register port
    input wire logic [3:0] reg_addr,
    input wire logic [15:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    input wire logic [15:0] reg_rdata,
    // converter core
    input wire logic conv_done,
    input wire logic conv_trigger,
    // configuration and interrupt
    input wire logic [2:0] reference_select,
    input wire logic [3:0] channel_select,
    input wire logic conversion_enable,
    input wire logic format_select,
    input wire logic [1:0] resolution,
    input wire logic irq
);
    // ********************************
    // properties
    // ********************************
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (rst);
    sequence s_vec_write;
        reg_wr && reg_addr == arw_pkg::ADDR_INT_VEC && !conv_done && !conv_trigger;
    endsequence
    sequence s_quiet;
        !conv_done && !conv_trigger;
    endsequence
    property p_idle_zero;
        !reg_rd |=> reg_rdata == 16'h0000;
    endproperty
    a_idle_zero: assert property (p_idle_zero)
        else $error("read data not zero outside a read");
    property p_unmapped;
        reg_rd && reg_addr[3] |=> reg_rdata == 16'h0000;
    endproperty
    a_unmapped: assert property (p_unmapped)
        else $error("unmapped read not zero");
    property p_mctl_rsvd;
        reg_rd && reg_addr == arw_pkg::ADDR_MEM_CTL |=> reg_rdata[15:7] == 9'h000;
    endproperty
    a_mctl_rsvd: assert property (p_mctl_rsvd)
        else $error("memory control reserved bits set");
    property p_ie_rsvd;
        reg_rd && reg_addr == arw_pkg::ADDR_INT_EN |=> reg_rdata[15:6] == 10'h000;
    endproperty
    a_ie_rsvd: assert property (p_ie_rsvd)
        else $error("enable reserved bits set");
    property p_signed_low;
        reg_rd && reg_addr == arw_pkg::ADDR_RESULT && format_select |=>
            reg_rdata[3:0] == 4'h0 &&
            ($past(resolution) == arw_pkg::RES_12 || reg_rdata[5:4] == 2'h0) &&
            ($past(resolution) != arw_pkg::RES_8 || reg_rdata[7:6] == 2'h0);
    endproperty
    a_signed_low: assert property (p_signed_low)
        else $error("signed result low bits not zero");
    property p_gated_hold;
        reg_wr && reg_addr == arw_pkg::ADDR_MEM_CTL && conversion_enable |=>
            $stable(reference_select) && $stable(channel_select);
    endproperty
    a_gated_hold: assert property (p_gated_hold)
        else $error("gated field changed while enabled");
    property p_gated_take;
        reg_wr && reg_addr == arw_pkg::ADDR_MEM_CTL && !conversion_enable &&
            reg_wdata[3:0] <= arw_pkg::CHAN_MAX |=>
            reference_select == $past(reg_wdata[6:4]) && channel_select == $past(reg_wdata[3:0]);
    endproperty
    a_gated_take: assert property (p_gated_take)
        else $error("gated field write not taken");
    property p_enable_bit;
        reg_wr && reg_addr == arw_pkg::ADDR_CONV_CTL |=> conversion_enable == $past(reg_wdata[0]);
    endproperty
    a_enable_bit: assert property (p_enable_bit)
        else $error("enable bit not written");
    property p_vec_clear;
        s_vec_write ##1 s_quiet |=> !irq;
    endproperty
    a_vec_clear: assert property (p_vec_clear)
        else $error("irq high after vector write");
endmodule : arw_regs_sva
bind arw_regs arw_regs_sva u_sva (
    .core_clk(core_clk),
    .rst(rst),
    .reg_addr(reg_addr),
    .reg_wdata(reg_wdata),
    .reg_wr(reg_wr),
    .reg_rd(reg_rd),
    .reg_rdata(reg_rdata),
    .conv_done(conv_done),
    .conv_trigger(conv_trigger),
    .reference_select(reference_select),
    .channel_select(channel_select),
    .conversion_enable(conversion_enable),
    .format_select(format_select),
    .resolution(resolution),
    .irq(irq)
);

// ===== arw_regs_tb.sv
/*
 * self-checking bench for the converter register block.
 * assumes the strobe register port and one-cycle core event pulses.
 */
`timescale 1ns/1ns
module arw_regs_tb;
    logic core_clk = 1'b0;
    logic rst = 1'b1;
    logic [3:0] reg_addr = 4'h0;
    logic [15:0] reg_wdata = 16'h0000;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [15:0] reg_rdata;
    logic conv_done = 1'b0;
    logic [11:0] conv_result = 12'h000;
    logic conv_trigger = 1'b0;
    logic conv_busy = 1'b0;
    logic [3:0] conv_channel = 4'h0;
    logic [2:0] reference_select;
    logic [3:0] channel_select;
    logic conversion_enable;
    logic format_select;
    logic [1:0] resolution;
    logic [1:0] sequence_mode;
    logic irq;
    int mismatches = 0;
    int checked = 0;
    int cycles = 0;
    arw_regs u_dut (
        .core_clk(core_clk),
        .rst(rst),
        .reg_addr(reg_addr),
        .reg_wdata(reg_wdata),
        .reg_wr(reg_wr),
        .reg_rd(reg_rd),
        .reg_rdata(reg_rdata),
        .conv_done(conv_done),
        .conv_result(conv_result),
        .conv_trigger(conv_trigger),
        .conv_busy(conv_busy),
        .conv_channel(conv_channel),
        .reference_select(reference_select),
        .channel_select(channel_select),
        .conversion_enable(conversion_enable),
        .format_select(format_select),
        .resolution(resolution),
        .sequence_mode(sequence_mode),
        .irq(irq)
    );
    // ********************************
    // clock, timeout, tasks
    // ********************************
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    always @(posedge core_clk) begin
        cycles++;
        if (cycles == 2000) begin
            mismatches++;
            give_verdict();
        end
    end
    task automatic give_verdict();
        $display("checked %0d mismatches %0d", checked, mismatches);
        if (mismatches == 0 && checked > 0) $display("Test passed");
        else $display("Test failed");
        $finish;
    endtask : give_verdict
    task automatic cmp16(input logic [15:0] got, input logic [15:0] exp);
        checked++;
        if (got !== exp) begin
            mismatches++;
            $display("Error at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : cmp16
    task automatic wr(input logic [3:0] a, input logic [15:0] d);
        @(posedge core_clk);
        reg_wr <= 1'b1;
        reg_addr <= a;
        reg_wdata <= d;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        // let the written register settle before anyone looks at it
        #1;
    endtask : wr
    task automatic rd_chk(input logic [3:0] a, input logic [15:0] e);
        @(posedge core_clk);
        reg_rd <= 1'b1;
        reg_addr <= a;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1;
        cmp16(reg_rdata, e);
    endtask : rd_chk
    task automatic conv(input logic [11:0] r);
        @(posedge core_clk);
        conv_done <= 1'b1;
        conv_result <= r;
        @(posedge core_clk);
        conv_done <= 1'b0;
    endtask : conv
    // ********************************
    // main sequence
    // ********************************
    initial begin
        repeat (6) @(posedge core_clk);
        rst <= 1'b0;
        rd_chk(arw_pkg::ADDR_MEM_CTL, 16'h0000);
        rd_chk(arw_pkg::ADDR_HIGH_THR, arw_pkg::RST_HIGH_UNS);
        rd_chk(arw_pkg::ADDR_LOW_THR, arw_pkg::RST_LOW_UNS);
        rd_chk(arw_pkg::ADDR_INT_EN, 16'h0000);
        cmp16({14'h0, resolution}, {14'h0, arw_pkg::RES_10});
        wr(arw_pkg::ADDR_INT_EN, 16'hffff);
        rd_chk(arw_pkg::ADDR_INT_EN, 16'h003f);
        rd_chk(4'h9, 16'h0000);
        wr(arw_pkg::ADDR_MEM_CTL, 16'hffff);
        rd_chk(arw_pkg::ADDR_MEM_CTL, 16'h007e);
        cmp16({13'h0, reference_select}, 16'h0007);
        wr(arw_pkg::ADDR_CONV_CTL, 16'h0001);
        cmp16({15'h0, conversion_enable}, 16'h0001);
        wr(arw_pkg::ADDR_MEM_CTL, 16'h0012);
        rd_chk(arw_pkg::ADDR_MEM_CTL, 16'h007e);
        wr(arw_pkg::ADDR_CONV_CTL, 16'h0000);
        wr(arw_pkg::ADDR_MEM_CTL, 16'h0012);
        cmp16({12'h0, channel_select}, 16'h0002);
        conv_channel <= 4'h5;
        wr(arw_pkg::ADDR_CONV_CTL, 16'h0014);
        rd_chk(arw_pkg::ADDR_MEM_CTL, 16'h0015);
        conv_channel <= 4'h9;
        wr(arw_pkg::ADDR_CONV_CTL, 16'h0034);
        rd_chk(arw_pkg::ADDR_CONV_CTL, 16'h0034);
        cmp16({14'h0, sequence_mode}, {14'h0, arw_pkg::SEQ_REPEAT_SEQ});
        rd_chk(arw_pkg::ADDR_MEM_CTL, 16'h0019);
        wr(arw_pkg::ADDR_CONV_CTL, 16'h0004);
        rd_chk(arw_pkg::ADDR_MEM_CTL, 16'h0012);
        conv(12'h2a5);
        rd_chk(arw_pkg::ADDR_RESULT, 16'h02a5);
        // left justified view for 8, 10, 12 bit
        for (int i = 0; i < 3; i++) begin
            wr(arw_pkg::ADDR_CONV_CTL, 16'h0002 | (16'(i) << 2));
            conv(12'hfa5 >> (4 - 2 * i));
            rd_chk(arw_pkg::ADDR_RESULT, (16'hfa50 & (16'hffff << (8 - 2 * i))) ^ 16'h8000);
        end
        cmp16({15'h0, format_select}, 16'h0001);
        rd_chk(arw_pkg::ADDR_HIGH_THR, arw_pkg::RST_HIGH_SGN);
        rd_chk(arw_pkg::ADDR_LOW_THR, arw_pkg::RST_LOW_SGN);
        wr(arw_pkg::ADDR_HIGH_THR, 16'h4000);
        wr(arw_pkg::ADDR_LOW_THR, 16'hc000);
        // inside from the first result, above from the signed loop results
        rd_chk(arw_pkg::ADDR_INT_FLAGS, 16'h000a);
        conv(12'hf00);
        rd_chk(arw_pkg::ADDR_INT_FLAGS, 16'h0009);
        wr(arw_pkg::ADDR_CONV_CTL, 16'h0008);
        rd_chk(arw_pkg::ADDR_RESULT, 16'h0f00);
        wr(arw_pkg::ADDR_CONV_CTL, 16'h0004);
        wr(arw_pkg::ADDR_HIGH_THR, 16'h0200);
        wr(arw_pkg::ADDR_LOW_THR, 16'h0100);
        wr(arw_pkg::ADDR_INT_EN, 16'h0001);
        conv(12'h300);
        rd_chk(arw_pkg::ADDR_INT_VEC, {8'h00, arw_pkg::VEC_ABOVE});
        cmp16({15'h0, irq}, 16'h0001);
        wr(arw_pkg::ADDR_INT_EN, 16'h0000);
        rd_chk(arw_pkg::ADDR_INT_EN, 16'h0000);
        cmp16({15'h0, irq}, 16'h0000);
        wr(arw_pkg::ADDR_INT_EN, 16'h0008);
        rd_chk(arw_pkg::ADDR_INT_FLAGS, 16'h0009);
        conv(12'h050);
        rd_chk(arw_pkg::ADDR_INT_VEC, {8'h00, arw_pkg::VEC_RES_OVF});
        rd_chk(arw_pkg::ADDR_INT_FLAGS, 16'h0015);
        rd_chk(arw_pkg::ADDR_RESULT, 16'h0050);
        conv(12'h180);
        rd_chk(arw_pkg::ADDR_INT_VEC, {8'h00, arw_pkg::VEC_INSIDE});
        wr(arw_pkg::ADDR_INT_FLAGS, 16'h0001);
        rd_chk(arw_pkg::ADDR_INT_VEC, {8'h00, arw_pkg::VEC_COMPLETE});
        rd_chk(arw_pkg::ADDR_RESULT, 16'h0180);
        rd_chk(arw_pkg::ADDR_INT_FLAGS, 16'h0000);
        conv(12'h0a0);
        rd_chk(arw_pkg::ADDR_INT_VEC, {8'h00, arw_pkg::VEC_BELOW});
        // irq must be up before the vector write, or its clear proves nothing
        wr(arw_pkg::ADDR_INT_EN, 16'h0020);
        // trigger while still busy
        @(posedge core_clk);
        conv_busy <= 1'b1;
        conv_trigger <= 1'b1;
        @(posedge core_clk);
        conv_trigger <= 1'b0;
        conv_busy <= 1'b0;
        rd_chk(arw_pkg::ADDR_INT_VEC, {8'h00, arw_pkg::VEC_TIME_OVF});
        cmp16({15'h0, irq}, 16'h0001);
        wr(arw_pkg::ADDR_INT_VEC, 16'h0000);
        rd_chk(arw_pkg::ADDR_INT_FLAGS, 16'h0000);
        cmp16({15'h0, irq}, 16'h0000);
        give_verdict();
    end
endmodule : arw_regs_tb
